// ==== inc/soss_pkg.sv ====
// constants, codes and helpers shared by the oscillator select and switch block
// assumes one 250 MHz system clock; all figures below are in that clock's terms
package soss_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 4;
	localparam int PLL_START_NS    = 2000;
	localparam int FAIL_TIMEOUT_NS = 4000;
	localparam int CNT_W           = 10;
	// least time rounds up, longest time rounds down
	localparam logic [CNT_W-1:0] PLL_START_CYC = CNT_W'((PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] FAIL_CYC      = CNT_W'(FAIL_TIMEOUT_NS / CLK_PERIOD_NS);
	localparam logic [2:0]       SWITCH_EDGES  = 3'h4;

	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [11:0] ADDR_OSC_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CLK_DIV  = 12'h004;
	localparam logic [11:0] ADDR_TUNE     = 12'h008;
	localparam int CUR_LSB      = 12;
	localparam int NEW_LSB      = 8;
	localparam int SEL_LOCK_BIT = 7;
	localparam int PLL_LOCK_BIT = 5;
	localparam int FAIL_BIT     = 3;
	localparam int SEC_EN_BIT   = 1;
	localparam int SW_REQ_BIT   = 0;
	localparam int DOZE_LSB     = 12;
	localparam int DOZE_EN_BIT  = 11;
	localparam int FRC_DIV_LSB  = 8;
	localparam int TUNE_W       = 6;
	localparam logic [15:0] CLOCK_DIVIDER_REG_MASK = 16'h7F00;
	localparam logic [15:0] CLOCK_DIVIDER_REG_RST  = 16'h0100;
	localparam logic [5:0]  TUNE_RST    = 6'h00;

	// ----------------------------------------
	// configuration word fields
	// ----------------------------------------
	localparam int CFG_PRI_LSB  = 0;
	localparam int CFG_SWM_LSB  = 6;
	localparam int CFG_INIT_LSB = 8;

	// ----------------------------------------
	// source codes, primary modes, activity index
	// ----------------------------------------
	localparam logic [2:0] SRC_FRC     = 3'h0;
	localparam logic [2:0] SRC_FRC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI     = 3'h2;
	localparam logic [2:0] SRC_PRI_PLL = 3'h3;
	localparam logic [2:0] SRC_SEC     = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC    = 3'h5;
	localparam logic [2:0] SRC_RSVD    = 3'h6;
	localparam logic [2:0] SRC_FRC_DIV = 3'h7;
	localparam logic [1:0] PRI_EC      = 2'h0;
	localparam logic [1:0] PRI_XT      = 2'h1;
	localparam logic [1:0] PRI_HS      = 2'h2;
	localparam logic [1:0] IDX_PRI     = 2'h0;
	localparam logic [1:0] IDX_SEC     = 2'h1;
	localparam logic [1:0] IDX_FRC     = 2'h2;
	localparam logic [1:0] IDX_LOW_POWER_INTERNAL_RC    = 2'h3;

	typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_WAIT} soss_state_e;

	// which oscillator feeds a given source code
	function automatic logic [1:0] src_index(input logic [2:0] code);
		case (code)
			SRC_PRI, SRC_PRI_PLL: return IDX_PRI;
			SRC_SEC:              return IDX_SEC;
			SRC_LOW_POWER_INTERNAL_RC:             return IDX_LOW_POWER_INTERNAL_RC;
			default:              return IDX_FRC;
		endcase
	endfunction

	// only primary and fast rc may pass through the multiplier
	function automatic logic src_uses_pll(input logic [2:0] code);
		return (code == SRC_PRI_PLL) || (code == SRC_FRC_PLL);
	endfunction

	function automatic logic src_is_primary(input logic [2:0] code);
		return (code == SRC_PRI) || (code == SRC_PRI_PLL);
	endfunction
endpackage

// ==== hdl/soss_pow2_div.sv ====
// power-of-two divider of an enable pulse stream
// assumes tick_in is a one-cycle pulse on clock; ratio 0 passes pulses through
`timescale 1ns/1ps
module soss_pow2_div (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// pulse stream
	input  wire logic       tick_in,
	input  wire logic [2:0] ratio,
	output wire logic       tick_out
);
	typedef struct packed {
		logic [6:0] cnt;
		logic       tick;
	} soss_div_s;

	soss_div_s s_reg;
	soss_div_s s_next;
	logic [6:0] mask;

	// count input pulses, emit one per 2^ratio of them
	always_comb begin
		s_next = s_reg;
		mask = 7'((8'h01 << ratio) - 8'h01);
		s_next.tick = 1'b0;
		if (tick_in) begin
			if (s_reg.cnt >= mask) begin
				s_next.cnt = 7'h00;
				s_next.tick = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick_out = s_reg.tick;
endmodule // soss_pow2_div

// ==== hdl/soss_pll_x4.sv ====
// times-four pulse multiplier with start-up lock timer
// assumes reference pulses are at least four clock cycles apart when enabled
`timescale 1ns/1ps
module soss_pll_x4 (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// control and pulses
	input  wire logic enable,
	input  wire logic tick_in,
	output wire logic tick_out,
	output wire logic locked
);
	localparam int W = soss_pkg::CNT_W;

	typedef struct packed {
		logic [W-1:0] per;
		logic [W-1:0] since;
		logic [W-1:0] ph;
		logic [1:0]   extra;
		logic [W-1:0] lock_cnt;
		logic         locked;
		logic         tick;
	} soss_pll_s;

	soss_pll_s s_reg;
	soss_pll_s s_next;
	logic [W-1:0] quarter;

	// measure the reference period, then insert three evenly spaced pulses
	always_comb begin
		s_next = s_reg;
		quarter = {2'b00, s_reg.per[W-1:2]};
		s_next.tick = 1'b0;
		if (!enable) begin
			s_next = '0;
			s_next.tick = tick_in;
		end else begin
			if (s_reg.lock_cnt < soss_pkg::PLL_START_CYC) begin
				s_next.lock_cnt = s_reg.lock_cnt + 1'b1;
			end else begin
				s_next.locked = 1'b1;
			end
			if (tick_in) begin
				s_next.per = s_reg.since + 1'b1;
				s_next.since = '0;
				s_next.ph = '0;
				s_next.extra = 2'h0;
				s_next.tick = 1'b1;
			end else begin
				if (s_reg.since != '1) begin
					s_next.since = s_reg.since + 1'b1;
				end
				s_next.ph = s_reg.ph + 1'b1;
				// limitation: a reference slower than the counter span stops the extras
				if (quarter != '0 && s_next.ph == quarter && s_reg.extra != 2'h3) begin
					s_next.tick = 1'b1;
					s_next.ph = '0;
					s_next.extra = s_reg.extra + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick_out = s_reg.tick;
	assign locked = s_reg.locked;
endmodule // soss_pll_x4

// ==== hdl/soss_top.sv ====
// oscillator select and clock switch unit with apb register slave
// assumes oscillator activity arrives as asynchronous levels and the
// configuration word is stable from reset onward
`timescale 1ns/1ps
module soss_top (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	// non-volatile configuration
	input  wire logic [15:0] config_word,
	input  wire logic        out_pin_function_cfg,
	// oscillator activity
	input  wire logic        primary_pin_in,
	input  wire logic        secondary_pin_in,
	input  wire logic        fast_rc_osc,
	input  wire logic        low_power_rc_osc,
	// oscillator controls
	output wire logic        primary_osc_enable,
	output wire logic [1:0]  primary_mode_cfg,
	output wire logic        secondary_osc_enable,
	output wire logic [5:0]  fast_rc_trim,
	output wire logic [2:0]  current_source,
	output wire logic        clock_fail,
	// clock enables
	output wire logic        oscillator_clock_en,
	output wire logic        instruction_clock_en,
	output wire logic        cpu_clock_en,
	// primary output pin
	output wire logic        primary_pin_out_o,
	output wire logic        primary_pin_out_oe
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		soss_pkg::soss_state_e    st;
		logic [3:0]               s1;
		logic [3:0]               s2;
		logic [3:0]               s3;
		logic [2:0]               cur;
		logic [2:0]               nsrc;
		logic                     sw_req;
		logic                     cf;
		logic                     secondary_oscillator_en;
		logic                     sel_lock;
		logic [15:0]              clock_divider_reg;
		logic [5:0]               tune;
		logic [2:0]               sw_edges;
		logic [soss_pkg::CNT_W-1:0] sw_wait;
		logic [soss_pkg::CNT_W-1:0] fail_cnt;
		logic                     osc_tick;
		logic                     instr_tick;
		logic                     instr_ph;
		logic [15:0]              rdata;
	} soss_top_s;

	soss_top_s  s_reg;
	soss_top_s  s_next;
	logic [3:0] edges;
	logic [1:0] swm;
	logic [2:0] init_src;
	logic       failsafe_clock_monitor_on;
	logic       sw_allowed;
	logic       frc_div_tick;
	logic       pre_pll;
	logic       pll_en;
	logic       pll_tick;
	logic       pll_locked;
	logic       tgt_edge;
	logic       sw_complete;
	logic       fail;
	logic       acc;
	logic       wr_ctrl;
	logic       hit;
	logic [15:0] ctrl_img;

	// ----------------------------------------
	// configuration and source activity
	// ----------------------------------------
	// activity edges read the second and third stages only
	assign edges = s_reg.s2 & ~s_reg.s3;
	assign swm = config_word[soss_pkg::CFG_SWM_LSB +: 2];
	assign init_src = config_word[soss_pkg::CFG_INIT_LSB +: 3];
	assign failsafe_clock_monitor_on = (swm == 2'b00) && (s_reg.st != soss_pkg::ST_BOOT);
	// a locked selection only binds while the monitor is active
	assign sw_allowed = !swm[1] && !(s_reg.sel_lock && swm == 2'b00);

	// fast rc postscaler ahead of the source mux
	soss_pow2_div u_frc_div (
		.clock    (clock),
		.rst      (rst),
		.tick_in  (edges[soss_pkg::IDX_FRC]),
		.ratio    (s_reg.clock_divider_reg[soss_pkg::FRC_DIV_LSB +: 3]),
		.tick_out (frc_div_tick)
	);

	// source mux: exactly one oscillator feeds the clock
	assign pre_pll = (s_reg.cur == soss_pkg::SRC_FRC_DIV) ? frc_div_tick
		: edges[soss_pkg::src_index(s_reg.cur)];
	assign pll_en = soss_pkg::src_uses_pll(s_reg.cur) && (s_reg.st != soss_pkg::ST_BOOT);

	soss_pll_x4 u_pll (
		.clock    (clock),
		.rst      (rst),
		.enable   (pll_en),
		.tick_in  (pre_pll),
		.tick_out (pll_tick),
		.locked   (pll_locked)
	);

	// doze postscaler on the processor clock
	soss_pow2_div u_doze (
		.clock    (clock),
		.rst      (rst),
		.tick_in  (s_reg.osc_tick),
		.ratio    (s_reg.clock_divider_reg[soss_pkg::DOZE_EN_BIT] ? s_reg.clock_divider_reg[soss_pkg::DOZE_LSB +: 3] : 3'h0),
		.tick_out (cpu_clock_en)
	);

	// switch target activity and completion
	assign tgt_edge = edges[soss_pkg::src_index(s_reg.nsrc)];
	assign sw_complete = tgt_edge && (s_reg.sw_edges == soss_pkg::SWITCH_EDGES - 3'h1);
	// monitor trips when the running source stays silent too long
	assign fail = failsafe_clock_monitor_on && !pre_pll && (s_reg.fail_cnt == soss_pkg::FAIL_CYC - 1'b1);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign acc = psel && penable;
	always_comb begin
		if (paddr == soss_pkg::ADDR_OSC_CTRL) begin
			hit = 1'b1;
		end else if (paddr == soss_pkg::ADDR_CLK_DIV) begin
			hit = 1'b1;
		end else if (paddr == soss_pkg::ADDR_TUNE) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end
	assign wr_ctrl = acc && pwrite && (paddr == soss_pkg::ADDR_OSC_CTRL);

	// control register image; unused bits read as zero
	always_comb begin
		ctrl_img = 16'h0000;
		ctrl_img[soss_pkg::CUR_LSB +: 3] = s_reg.cur;
		ctrl_img[soss_pkg::NEW_LSB +: 3] = s_reg.nsrc;
		ctrl_img[soss_pkg::SEL_LOCK_BIT] = s_reg.sel_lock;
		ctrl_img[soss_pkg::PLL_LOCK_BIT] = pll_locked;
		ctrl_img[soss_pkg::FAIL_BIT] = s_reg.cf;
		ctrl_img[soss_pkg::SEC_EN_BIT] = s_reg.secondary_oscillator_en;
		ctrl_img[soss_pkg::SW_REQ_BIT] = s_reg.sw_req;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		// two-stage sync; the secondary is held quiet while disabled
		s_next.s1 = {low_power_rc_osc, fast_rc_osc, secondary_pin_in, primary_pin_in};
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		if (!s_reg.secondary_oscillator_en) begin
			s_next.s2[soss_pkg::IDX_SEC] = 1'b0;
		end

		// clock enables, instruction clock on every second oscillator pulse
		s_next.osc_tick = pll_tick;
		s_next.instr_ph = s_reg.instr_ph ^ pll_tick;
		s_next.instr_tick = pll_tick && s_reg.instr_ph;

		// monitor counter restarts on each active-source pulse
		if (pre_pll || !failsafe_clock_monitor_on || fail) begin
			s_next.fail_cnt = '0;
		end else begin
			s_next.fail_cnt = s_reg.fail_cnt + 1'b1;
		end

		// switch sequencer
		case (s_reg.st)
			soss_pkg::ST_BOOT: begin
				// reserved power-on code falls back to divided fast rc
				if (init_src == soss_pkg::SRC_RSVD) begin
					s_next.cur = soss_pkg::SRC_FRC_DIV;
				end else begin
					s_next.cur = init_src;
				end
				s_next.nsrc = s_next.cur;
				s_next.st = soss_pkg::ST_IDLE;
			end
			soss_pkg::ST_IDLE: begin
				if (s_reg.sw_req) begin
					if (!sw_allowed || s_reg.nsrc == soss_pkg::SRC_RSVD || s_reg.nsrc == s_reg.cur) begin
						s_next.sw_req = 1'b0;
					end else begin
						s_next.st = soss_pkg::ST_WAIT;
						s_next.sw_edges = 3'h0;
						s_next.sw_wait = '0;
					end
				end
			end
			soss_pkg::ST_WAIT: begin
				// keep the old clock until the target has proven itself
				if (sw_complete) begin
					s_next.cur = s_reg.nsrc;
					s_next.sw_req = 1'b0;
					s_next.st = soss_pkg::ST_IDLE;
				end else if (s_reg.sw_wait == soss_pkg::FAIL_CYC - 1'b1) begin
					s_next.sw_req = 1'b0;
					s_next.st = soss_pkg::ST_IDLE;
				end else begin
					s_next.sw_wait = s_reg.sw_wait + 1'b1;
					if (tgt_edge) begin
						s_next.sw_edges = s_reg.sw_edges + 3'h1;
					end
				end
			end
			default: begin
				s_next.st = soss_pkg::ST_IDLE;
			end
		endcase

		// clock loss forces the fast rc and aborts a pending switch
		if (fail) begin
			s_next.cur = soss_pkg::SRC_FRC;
			s_next.sw_req = 1'b0;
			s_next.st = soss_pkg::ST_IDLE;
		end

		// register writes take effect in the access phase
		if (acc && pwrite) begin
			if (paddr == soss_pkg::ADDR_OSC_CTRL) begin
				// the target is frozen while a switch is in flight
				if (s_reg.st != soss_pkg::ST_WAIT) begin
					s_next.nsrc = pwdata[soss_pkg::NEW_LSB +: 3];
				end
				s_next.secondary_oscillator_en = pwdata[soss_pkg::SEC_EN_BIT];
				if (pwdata[soss_pkg::SW_REQ_BIT]) begin
					s_next.sw_req = 1'b1;
				end
				if (pwdata[soss_pkg::SEL_LOCK_BIT]) begin
					s_next.sel_lock = 1'b1;
				end
				if (!pwdata[soss_pkg::FAIL_BIT]) begin
					s_next.cf = 1'b0;
				end
			end else if (paddr == soss_pkg::ADDR_CLK_DIV) begin
				s_next.clock_divider_reg = pwdata[15:0] & soss_pkg::CLOCK_DIVIDER_REG_MASK;
			end else if (paddr == soss_pkg::ADDR_TUNE) begin
				s_next.tune = pwdata[soss_pkg::TUNE_W-1:0];
			end
		end

		// a failure in the clearing cycle still sets the flag
		if (fail) begin
			s_next.cf = 1'b1;
		end

		// read data is captured in the setup phase
		if (psel && !penable) begin
			if (paddr == soss_pkg::ADDR_OSC_CTRL) begin
				s_next.rdata = ctrl_img;
			end else if (paddr == soss_pkg::ADDR_CLK_DIV) begin
				s_next.rdata = s_reg.clock_divider_reg;
			end else if (paddr == soss_pkg::ADDR_TUNE) begin
				s_next.rdata = {10'h000, s_reg.tune};
			end else begin
				s_next.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.st <= soss_pkg::ST_BOOT;
			s_reg.cur <= soss_pkg::SRC_FRC_DIV;
			s_reg.nsrc <= soss_pkg::SRC_FRC_DIV;
			s_reg.clock_divider_reg <= soss_pkg::CLOCK_DIVIDER_REG_RST;
			s_reg.tune <= soss_pkg::TUNE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign pready = acc;
	assign pslverr = acc && !hit;
	assign prdata = {16'h0000, s_reg.rdata};
	assign primary_mode_cfg = config_word[soss_pkg::CFG_PRI_LSB +: 2];
	// the primary runs while it is selected or is being switched to
	assign primary_osc_enable = soss_pkg::src_is_primary(s_reg.cur)
		|| (s_reg.st == soss_pkg::ST_WAIT && soss_pkg::src_is_primary(s_reg.nsrc));
	assign secondary_osc_enable = s_reg.secondary_oscillator_en;
	assign fast_rc_trim = s_reg.tune;
	assign current_source = s_reg.cur;
	assign clock_fail = s_reg.cf;
	assign oscillator_clock_en = s_reg.osc_tick;
	assign instruction_clock_en = s_reg.instr_tick;
	assign primary_pin_out_o = s_reg.instr_ph;
	// crystal modes own the pin; external clock or non-primary may output the clock
	assign primary_pin_out_oe = soss_pkg::src_is_primary(s_reg.cur)
		? (primary_mode_cfg == soss_pkg::PRI_EC)
		: out_pin_function_cfg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence seq_switch_done;
		s_reg.st == soss_pkg::ST_WAIT && sw_complete && !fail;
	endsequence

	sequence seq_blocked;
		s_reg.st == soss_pkg::ST_IDLE && s_reg.sw_req && !sw_allowed && !wr_ctrl;
	endsequence

	AST_NO_RSVD: assert property (s_reg.st != soss_pkg::ST_BOOT |-> s_reg.cur != soss_pkg::SRC_RSVD)
		else $error("reserved source selected");
	AST_LOCKED_CFG: assert property (swm[1] && s_reg.st == soss_pkg::ST_IDLE |=> $stable(s_reg.cur))
		else $error("source changed while switching disabled");
	AST_NO_FAILSAFE_CLOCK_MONITOR: assert property (swm != 2'b00 |-> !fail)
		else $error("monitor tripped while disabled");
	AST_CF_SET: assert property (fail |=> s_reg.cf && s_reg.cur == soss_pkg::SRC_FRC)
		else $error("clock failure not flagged");
	AST_INSTR_HALF: assert property (s_reg.instr_tick |-> s_reg.osc_tick && !s_reg.instr_ph)
		else $error("instruction pulse without paired oscillator pulse");
	AST_SW_DONE: assert property (seq_switch_done |=> s_reg.cur == $past(s_reg.nsrc) && !s_reg.sw_req)
		else $error("switch completion did not copy source");
	AST_PLL_ONLY: assert property (pll_locked |-> soss_pkg::src_uses_pll($past(s_reg.cur)))
		else $error("lock reported on non-multiplied source");
	AST_IGNORE: assert property (seq_blocked |=> s_reg.st == soss_pkg::ST_IDLE && !s_reg.sw_req)
		else $error("blocked request not dropped");
	AST_SWITCH_BOUND: assert property ($rose(s_reg.st == soss_pkg::ST_WAIT) |-> ##[1:1000] s_reg.st != soss_pkg::ST_WAIT)
		else $error("switch never ended");
endmodule // soss_top

// ==== dv/soss_osc_model.sv ====
// activity model of the four oscillators that feed the select block
// assumes the bench clock; a disabled or stalled source holds its line low
`timescale 1ns/1ps
module soss_osc_model (
	// clock
	input  wire logic clock,
	// controls
	input  wire logic pri_en,
	input  wire logic sec_en,
	input  wire logic frc_stop,
	// activity levels
	output logic      pri_o,
	output logic      sec_o,
	output logic      frc_o,
	output logic      low_power_internal_rc_o
);
	logic [7:0] n = 8'h00;
	// each source runs at its own rate so that a switch can be told apart
	always @(posedge clock) begin
		n      <= n + 8'h01;
		pri_o  <= pri_en & n[1];
		sec_o  <= sec_en & n[4];
		frc_o  <= ~frc_stop & n[2];
		low_power_internal_rc_o <= n[5];
	end
endmodule // soss_osc_model

// ==== dv/tb.sv ====
// self-checking bench for the oscillator select and switch block
// assumes zero-wait apb slave and the activity model beside it
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb;
	logic        clock, rst, psel, penable, pwrite, pinfn, frc_stop, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] cfg;
	logic        pri_in, sec_in, frc_in, lp_in, pri_en, sec_en, fail, osc_en, ins_en, oe, cpu_en;
	logic [1:0]  pmode;
	logic [5:0]  trim;
	logic [2:0]  cur;
	int          err_count = 0;
	int          cmp_count = 0;
	int          i, k;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;} soss_row_s;
	soss_row_s rows [5] = '{
		'{1'b0, soss_pkg::ADDR_CLK_DIV, 32'h0, {16'h0, soss_pkg::CLOCK_DIVIDER_REG_RST}, 1'b0},
		'{1'b0, soss_pkg::ADDR_TUNE, 32'h0, 32'h0, 1'b0},
		'{1'b1, soss_pkg::ADDR_TUNE, 32'h2A, 32'h2A, 1'b0},
		'{1'b1, soss_pkg::ADDR_CLK_DIV, 32'hFFFF, {16'h0, soss_pkg::CLOCK_DIVIDER_REG_MASK}, 1'b0},
		'{1'b1, 12'h00C, 32'hFFFF, 32'h0, 1'b1}};

	soss_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.config_word(cfg), .out_pin_function_cfg(pinfn), .primary_pin_in(pri_in),
		.secondary_pin_in(sec_in), .fast_rc_osc(frc_in), .low_power_rc_osc(lp_in),
		.primary_osc_enable(pri_en), .primary_mode_cfg(pmode), .secondary_osc_enable(sec_en),
		.fast_rc_trim(trim), .current_source(cur), .clock_fail(fail), .oscillator_clock_en(osc_en),
		.instruction_clock_en(ins_en), .cpu_clock_en(cpu_en), .primary_pin_out_o(),
		.primary_pin_out_oe(oe));
	soss_osc_model osc (.clock(clock), .pri_en(pri_en), .sec_en(sec_en), .frc_stop(frc_stop),
		.pri_o(pri_in), .sec_o(sec_in), .frc_o(frc_in), .low_power_internal_rc_o(lp_in));

	// --------------------------------
	// tasks
	// --------------------------------
	// one transfer; a spare edge first keeps two calls from driving in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// no cycle count is assumed: only the watchdog ends a hung access
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll until the device drops the switch request
	task automatic wsw();
		int n;
		n = 0;
		do begin apb(1'b0, soss_pkg::ADDR_OSC_CTRL, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 500);
		`CHK(rd[0], 1'b0)
	endtask
	task automatic reset(input logic [15:0] c, input logic p);
		cfg <= c;
		pinfn <= p;
		rst <= 1'b1;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	task automatic tend(input string s);
		$display("test %s done, mismatches %0d", s, err_count);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// --------------------------------
	// clock, watchdog, tests
	// --------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// whole run is near 3600 cycles
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		end_sim();
	end
	initial begin
		{rst, psel, penable, pwrite, frc_stop} = 5'h10;
		{paddr, pwdata, cfg, pinfn} = '0;
		// blank configuration: switching and monitor both off
		reset(16'h07C0, 1'b0);
		`CHK(cur, 3'h7)
		`CHK(oe, 1'b0)
		// postscaler at its reset ratio halves the fast rc: 16 cycles between pulses
		@(posedge clock iff osc_en === 1'b1);
		k = 0;
		do begin @(posedge clock); k++; end while (osc_en !== 1'b1);
		`CHK(k, 16)
		for (i = 0; i < 5; i++) begin
			if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			`CHK(rd, rows[i].e)
			`CHK(er, rows[i].s)
		end
		`CHK(trim, 6'h2A)
		tend("registers");
		// fast rc keeps running so that an allowed switch would show within the wait
		apb(1'b1, soss_pkg::ADDR_OSC_CTRL, 32'h0001);
		repeat (100) @(posedge clock);
		apb(1'b0, soss_pkg::ADDR_OSC_CTRL, 32'h0);
		`CHK(rd[14:12], 3'h7)
		`CHK(rd[0], 1'b0)
		frc_stop <= 1'b1;
		repeat (1100) @(posedge clock);
		`CHK(fail, 1'b0)
		frc_stop <= 1'b0;
		tend("locked config");
		// switching and monitor enabled, start on plain fast rc
		reset(16'h0000, 1'b1);
		`CHK(cur, 3'h0)
		`CHK(oe, 1'b1)
		k = 0;
		@(posedge clock iff ins_en === 1'b1);
		repeat (8) do begin @(posedge clock); k += int'(osc_en === 1'b1); end while (ins_en !== 1'b1);
		`CHK(k, 16)
		tend("instruction clock");
		apb(1'b1, soss_pkg::ADDR_OSC_CTRL, 32'h0403);
		// the write lands at the edge that ends the access; look once it has settled
		@(posedge clock);
		`CHK(sec_en, 1'b1)
		wsw();
		`CHK(cur, 3'h4)
		apb(1'b1, soss_pkg::ADDR_OSC_CTRL, 32'h0603);
		wsw();
		`CHK(cur, 3'h4)
		tend("switch");
		apb(1'b1, soss_pkg::ADDR_OSC_CTRL, 32'h0103);
		wsw();
		`CHK(cur, 3'h1)
		`CHK(rd[5], 1'b0)
		repeat (520) @(posedge clock);
		apb(1'b0, soss_pkg::ADDR_OSC_CTRL, 32'h0);
		`CHK(rd[5], 1'b1)
		tend("multiplier");
		frc_stop <= 1'b1;
		repeat (1100) @(posedge clock);
		`CHK(fail, 1'b1)
		`CHK(cur, 3'h0)
		frc_stop <= 1'b0;
		repeat (20) @(posedge clock);
		apb(1'b1, soss_pkg::ADDR_OSC_CTRL, 32'h0002);
		@(posedge clock);
		`CHK(fail, 1'b0)
		tend("monitor");
		// high-speed crystal on the primary: the crystal owns the output pin
		reset(16'h0202, 1'b1);
		`CHK(cur, 3'h2)
		`CHK(pmode, 2'h2)
		`CHK(oe, 1'b0)
		`CHK(pri_en, 1'b1)
		// doze ratio one: two oscillator pulses per processor pulse
		apb(1'b1, soss_pkg::ADDR_CLK_DIV, 32'h1800);
		k = 0;
		@(posedge clock iff cpu_en === 1'b1);
		repeat (4) do begin @(posedge clock); k += int'(osc_en === 1'b1); end while (cpu_en !== 1'b1);
		`CHK(k, 8)
		apb(1'b1, soss_pkg::ADDR_OSC_CTRL, 32'h0501);
		wsw();
		`CHK(cur, 3'h5)
		`CHK(pri_en, 1'b0)
		// external clock on the primary: the pin carries the instruction clock
		reset(16'h0200, 1'b0);
		`CHK(pmode, 2'h0)
		`CHK(oe, 1'b1)
		tend("primary");
		end_sim();
	end
endmodule // tb
